// >>> hdl/dcm_pkg.sv
// Constants, types and command codes shared by the DAC control and monitor block
// What this block does
// RULE_01 - Special commands decode only with both register-select bits zero, address as code.
// RULE_02 - Code 001100 writes the control register, or reads it back when read bit set.
// RULE_03 - Power-down output state bit: set gives high impedance (default), clear 100k load.
// RULE_04 - Reference level bit: set 2.5 V, clear 1.25 V; default depends on variant.
// RULE_05 - Amplifier boost bit raises bias when set; clear, reduced bias, is default.
// RULE_06 - Reference source bit: set internal reference, clear external reference (default).
// RULE_07 - With monitor enabled, each monitor-select command routes the chosen channel out.
// RULE_08 - With monitor disabled (default), the shared pin is the last channel's output.
// RULE_09 - Thermal protect bit powers down all amplifiers above 130 C; default disabled.
// RULE_10 - After thermal shutdown, soft power-up re-enables amplifiers only below 130 C.
// RULE_11 - Values written to control bits 7, 1 and 0 are ignored.
// RULE_12 - Each toggle-enable bit puts its eight-channel group in or out of toggle mode.
// RULE_13 - Toggle bits ascend: lowest bit channels 0-7, highest bit channels 32-39.
// RULE_14 - In toggle mode each load strobe swaps a channel between its A and B codes.
// RULE_15 - Monitor-select is code 001010; upper six data bits address, lower eight ignored.
// RULE_16 - Host sets monitor enable before any monitor-select that routes a channel.
// RULE_17 - Monitor addresses 0-38 route that channel; 39-62 give undefined results.
// RULE_18 - Monitor address 63 puts the monitor output in high impedance.
// RULE_19 - While monitoring, the last channel pin is the monitor, not its own DAC.
// RULE_20 - Soft reset command returns all internal registers to defaults; the code keeps the amplifier power state.
// RULE_21 - Readback returns last written defined bits, zero for bits without function.
package dcm_pkg;

  // Channel organisation
  localparam int NUM_CH         = 40;
  localparam int GROUP_SIZE     = 8;
  localparam int NUM_GROUPS     = 5;
  localparam int DATA_W         = 14;
  localparam int ADDR_W         = 6;

  // Register-select code for the special-function space
  localparam logic [1:0] SEL_SFR = 2'h0;

  // Special-function command codes
  localparam logic [5:0] CMD_SOFT_PD  = 6'h08;
  localparam logic [5:0] CMD_SOFT_PU  = 6'h09;
  localparam logic [5:0] CMD_MON_SEL  = 6'h0a;
  localparam logic [5:0] CMD_CTRL     = 6'h0c;
  localparam logic [5:0] CMD_SOFT_RST = 6'h0f;

  // Control register field positions
  localparam int CR_PD_STATE   = 13;
  localparam int CR_REF_LEVEL  = 12;
  localparam int CR_BOOST      = 11;
  localparam int CR_REF_INT    = 10;
  localparam int CR_MON_EN     = 9;
  localparam int CR_THERM_EN   = 8;
  localparam int CR_TOGGLE_LSB = 2;

  // Control register reset value (reference level bit added per variant) and defined bits
  localparam logic [13:0] CTRL_RESET   = 14'h2000;
  localparam logic [13:0] CTRL_DEFINED = 14'h3f7c;

  // Monitor data field and special addresses
  localparam int MON_ADDR_LSB             = 8;
  localparam logic [5:0] MON_LAST_ROUTED  = 6'h26;
  localparam logic [5:0] MON_HIZ_ADDR     = 6'h3f;

  // Incoming command word from the host interface
  typedef struct packed {
    logic              rw;
    logic [1:0]        reg_sel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dcm_cmd_s;

  // Decoded special-function strobes
  typedef struct packed {
    logic ctrl_wr;
    logic ctrl_rd;
    logic mon_sel;
    logic soft_pd;
    logic soft_pu;
    logic soft_rst;
  } dcm_dec_s;

  // Amplifier power states
  typedef enum logic [2:0] {
    AMP_ON       = 3'b001,
    AMP_SOFT_PD  = 3'b010,
    AMP_THERM_PD = 3'b100
  } dcm_amp_e;

endpackage : dcm_pkg

// >>> hdl/dcm_cmd_decode.sv
// Special-function command decoder
`timescale 1ns/1ps
module dcm_cmd_decode
  import dcm_pkg::*;
(
  input  wire logic     cmd_valid,
  input  dcm_cmd_s      cmd,
  output dcm_dec_s      dec
);

  // True when the word targets the special-function space with a given code
  function automatic logic is_sfr(input dcm_cmd_s c, input logic [5:0] code);
    is_sfr = (c.reg_sel == SEL_SFR) && (c.addr == code);  // [RULE_01]
  endfunction : is_sfr

  // One strobe per recognised command
  always_comb begin
    dec          = '0;
    dec.ctrl_wr  = cmd_valid && is_sfr(cmd, CMD_CTRL) && !cmd.rw;  // [RULE_02]
    dec.ctrl_rd  = cmd_valid && is_sfr(cmd, CMD_CTRL) && cmd.rw;   // [RULE_02]
    dec.mon_sel  = cmd_valid && is_sfr(cmd, CMD_MON_SEL) && !cmd.rw;  // [RULE_15]
    dec.soft_pd  = cmd_valid && is_sfr(cmd, CMD_SOFT_PD) && !cmd.rw;
    dec.soft_pu  = cmd_valid && is_sfr(cmd, CMD_SOFT_PU) && !cmd.rw;
    dec.soft_rst = cmd_valid && is_sfr(cmd, CMD_SOFT_RST) && !cmd.rw;
  end

endmodule : dcm_cmd_decode

// >>> hdl/dcm_amp_power.sv
// Amplifier power state: soft power-down, soft power-up and thermal shutdown
`timescale 1ns/1ps
module dcm_amp_power
  import dcm_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic protect_en,
  input  wire logic over_temp,
  input  wire logic soft_pd,
  input  wire logic soft_pu,
  output dcm_amp_e  amp_state
);

  typedef struct packed {
    dcm_amp_e state;
  } dcm_pwr_s;

  dcm_pwr_s s_q;
  dcm_pwr_s s_d;

  // Next power state
  always_comb begin
    s_d = s_q;
    case (s_q.state)
      AMP_ON: begin
        if (protect_en && over_temp) begin
          s_d.state = AMP_THERM_PD;  // [RULE_09]
        end else if (soft_pd) begin
          s_d.state = AMP_SOFT_PD;
        end
      end
      AMP_SOFT_PD: begin
        if (soft_pu && !(protect_en && over_temp)) begin
          s_d.state = AMP_ON;
        end
      end
      AMP_THERM_PD: begin
        if (soft_pu && !over_temp) begin
          s_d.state = AMP_ON;  // [RULE_10]
        end else if (soft_pd) begin
          s_d.state = AMP_SOFT_PD;
        end
      end
      default: begin
        s_d.state = AMP_ON;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q.state <= AMP_ON;
    end else begin
      s_q <= s_d;
    end
  end

  assign amp_state = s_q.state;

endmodule : dcm_amp_power

// >>> hdl/dcm_top.sv
// Control register, channel monitor select and toggle logic of the 40-channel DAC
`timescale 1ns/1ps
module dcm_top
  import dcm_pkg::*;
#(
  parameter bit REF_LEVEL_DEFAULT = 1'b1
)
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                cmd_valid,
  input  dcm_cmd_s                 cmd,
  input  wire logic                over_temp_pin,
  input  wire logic                load_dac_strobe_n,
  output logic                     rd_valid,
  output logic [DATA_W-1:0]        rd_data,
  output logic                     powerdown_output_state,
  output logic                     ref_level_select,
  output logic                     amp_boost,
  output logic                     ref_source_internal,
  output logic                     monitor_enable_bit,
  output logic                     thermal_protect_enable,
  output logic [NUM_GROUPS-1:0]    group_toggle_enables,
  output logic [NUM_CH-1:0]        channel_toggle_mode,
  output logic [NUM_CH-1:0]        channel_b_select,
  output logic                     amps_powered,
  output logic                     thermal_shutdown,
  output logic [ADDR_W-1:0]        monitor_channel,
  output logic                     monitor_route_active,
  output logic                     monitor_output_hiz,
  output logic                     monitor_undefined,
  output logic                     last_channel_output_is_dac
);

  // Elaboration checks on the channel organisation
  if (NUM_CH != NUM_GROUPS * GROUP_SIZE) begin : g_chk_groups
    $error("channel count must equal groups times group size");
  end
  if (NUM_CH > 63) begin : g_chk_addr
    $error("channel count must leave address 63 free");
  end

  // State of the block except the amplifier power state held in u_power
  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic [ADDR_W-1:0] mon_ch;
    logic              mon_sel_seen;
    logic [NUM_CH-1:0] tmode;
    logic [NUM_CH-1:0] bsel;
    logic [1:0]        ot_sync;
    logic [2:0]        load_dac_strobe_sync;
    logic              rd_valid;
    logic [DATA_W-1:0] rd_data;
    logic              route;
    logic              hiz;
    logic              undef;
    logic              last_dac;
    logic              powered;
    logic              therm;
  } dcm_state_s;

  dcm_state_s s_q;
  dcm_state_s s_d;
  dcm_dec_s   dec;
  dcm_amp_e   amp_state;
  logic       over_temp;
  logic       load_dac_strobe_fall;

  // Control register value after power-up or soft reset
  function automatic logic [DATA_W-1:0] ctrl_default(input logic ref_lvl);
    logic [DATA_W-1:0] v;
    v               = CTRL_RESET;
    v[CR_REF_LEVEL] = ref_lvl;  // [RULE_04]
    ctrl_default    = v;
  endfunction : ctrl_default

  // Expand the five group bits into one toggle flag per channel
  function automatic logic [NUM_CH-1:0] expand_groups(input logic [NUM_GROUPS-1:0] g);
    logic [NUM_CH-1:0] m;
    m = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      m[c] = g[c / GROUP_SIZE];  // [RULE_13]
    end
    expand_groups = m;
  endfunction : expand_groups

  // Command decoder
  dcm_cmd_decode u_decode (
    .cmd_valid (cmd_valid),
    .cmd       (cmd),
    .dec       (dec)
  );

  // Amplifier power control
  dcm_amp_power u_power (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .protect_en (s_q.ctrl[CR_THERM_EN]),
    .over_temp  (over_temp),
    .soft_pd    (dec.soft_pd),
    .soft_pu    (dec.soft_pu),
    .amp_state  (amp_state)
  );

  // Synchronised pin levels and load strobe falling edge
  assign over_temp = s_q.ot_sync[1];
  assign load_dac_strobe_fall = !s_q.load_dac_strobe_sync[1] && s_q.load_dac_strobe_sync[2];

  // Next state
  always_comb begin
    logic write_ok;
    logic [ADDR_W-1:0] addr;
    write_ok = 1'b0;
    addr     = '0;
    s_d      = s_q;

    // Pin synchronisers, the first stage feeds only the second
    s_d.ot_sync   = {s_q.ot_sync[0], over_temp_pin};
    s_d.load_dac_strobe_sync = {s_q.load_dac_strobe_sync[1:0], load_dac_strobe_n};

    // Control and monitor-select writes are dropped while soft powered down; soft reset still applies
    write_ok = (amp_state != AMP_SOFT_PD);

    // Control register write keeps only the defined bits
    if (dec.ctrl_wr && write_ok) begin
      s_d.ctrl = cmd.data & CTRL_DEFINED;  // [RULE_02] [RULE_11]
    end

    // Monitor select: upper data bits form the channel address
    if (dec.mon_sel && write_ok) begin
      s_d.mon_ch       = cmd.data[MON_ADDR_LSB +: ADDR_W];  // [RULE_15]
      s_d.mon_sel_seen = 1'b1;  // [RULE_07]
    end

    // Readback answers one cycle after the read command
    s_d.rd_valid = dec.ctrl_rd;  // [RULE_02]
    if (dec.ctrl_rd) begin
      s_d.rd_data = s_q.ctrl & CTRL_DEFINED;  // [RULE_21]
    end

    // Soft reset returns the control, monitor select and B select registers to their defaults; the amplifier power state is kept
    if (dec.soft_rst) begin
      s_d.ctrl         = ctrl_default(REF_LEVEL_DEFAULT);  // [RULE_20]
      s_d.mon_ch       = '0;
      s_d.mon_sel_seen = 1'b0;
      s_d.bsel         = '0;
    end

    // Toggle mode per channel from the group enables
    s_d.tmode = expand_groups(s_d.ctrl[CR_TOGGLE_LSB +: NUM_GROUPS]);  // [RULE_12]

    // Load strobe swaps A and B for toggling channels, others stay on A
    for (int c = 0; c < NUM_CH; c++) begin
      if (!s_d.tmode[c]) begin
        s_d.bsel[c] = 1'b0;
      end else if (load_dac_strobe_fall && !dec.soft_rst) begin
        s_d.bsel[c] = !s_q.bsel[c];  // [RULE_14]
      end
    end

    // Monitor routing from the enable bit and the last selected address
    addr       = s_d.mon_ch;
    s_d.route  = 1'b0;
    s_d.hiz    = 1'b0;
    s_d.undef  = 1'b0;
    if (s_d.ctrl[CR_MON_EN] && s_d.mon_sel_seen) begin
      if (addr == MON_HIZ_ADDR) begin
        s_d.hiz = 1'b1;  // [RULE_18]
      end else if (addr <= MON_LAST_ROUTED) begin
        s_d.route = 1'b1;  // [RULE_17] [RULE_07]
      end else begin
        s_d.undef = 1'b1;  // [RULE_17]
      end
    end

    // The last channel pin is the DAC output unless monitoring is on
    s_d.last_dac = !s_d.ctrl[CR_MON_EN];  // [RULE_08] [RULE_19]

    // Power status flags
    s_d.powered = (amp_state == AMP_ON);
    s_d.therm   = (amp_state == AMP_THERM_PD);  // [RULE_09]
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q              <= '0;
      s_q.ctrl         <= ctrl_default(REF_LEVEL_DEFAULT);  // [RULE_03] [RULE_05] [RULE_06]
      s_q.ot_sync      <= 2'h0;
      s_q.load_dac_strobe_sync    <= 3'h7;
      s_q.last_dac     <= 1'b1;  // [RULE_08]
      s_q.powered      <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign rd_valid                   = s_q.rd_valid;
  assign rd_data                    = s_q.rd_data;
  assign powerdown_output_state     = s_q.ctrl[CR_PD_STATE];  // [RULE_03]
  assign ref_level_select           = s_q.ctrl[CR_REF_LEVEL];  // [RULE_04]
  assign amp_boost                  = s_q.ctrl[CR_BOOST];  // [RULE_05]
  assign ref_source_internal        = s_q.ctrl[CR_REF_INT];  // [RULE_06]
  assign monitor_enable_bit         = s_q.ctrl[CR_MON_EN];
  assign thermal_protect_enable     = s_q.ctrl[CR_THERM_EN];
  assign group_toggle_enables       = s_q.ctrl[CR_TOGGLE_LSB +: NUM_GROUPS];
  assign channel_toggle_mode        = s_q.tmode;
  assign channel_b_select           = s_q.bsel;
  assign amps_powered               = s_q.powered;
  assign thermal_shutdown           = s_q.therm;
  assign monitor_channel            = s_q.mon_ch;
  assign monitor_route_active       = s_q.route;
  assign monitor_output_hiz         = s_q.hiz;
  assign monitor_undefined          = s_q.undef;
  assign last_channel_output_is_dac = s_q.last_dac;

endmodule : dcm_top

// >>> testbench/dcm_top_monitor.sv
// Checker of the control register and monitor select of dcm_top
`timescale 1ns/1ps
module dcm_top_monitor
  import dcm_pkg::*;
#(
  parameter bit REF_LEVEL_DEFAULT = 1'b1
)
(
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              cmd_valid,
  input dcm_cmd_s               cmd,
  input wire logic              rd_valid,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              powerdown_output_state,
  input wire logic              ref_level_select,
  input wire logic              amp_boost,
  input wire logic              ref_source_internal,
  input wire logic              monitor_enable_bit,
  input wire logic              thermal_protect_enable,
  input wire logic [4:0]        group_toggle_enables,
  input wire logic [NUM_CH-1:0] channel_toggle_mode,
  input wire logic              amps_powered,
  input wire logic              thermal_shutdown,
  input wire logic [5:0]        monitor_channel,
  input wire logic              monitor_route_active,
  input wire logic              monitor_output_hiz,
  input wire logic              last_channel_output_is_dac
);
  localparam logic [13:0] CTRL_DFLT = CTRL_RESET | {1'b0, REF_LEVEL_DEFAULT, 12'h000};
  logic [13:0]       ctrl;
  logic [NUM_CH-1:0] tmap;
  logic              sfr, wr, rd, mon, pd_q;
  // Control bits in register order, expected toggle map and decoded commands
  assign ctrl = {powerdown_output_state, ref_level_select, amp_boost, ref_source_internal,
                 monitor_enable_bit, thermal_protect_enable, 1'b0, group_toggle_enables, 2'b00};
  assign tmap = {{8{group_toggle_enables[4]}}, {8{group_toggle_enables[3]}},
                 {8{group_toggle_enables[2]}}, {8{group_toggle_enables[1]}},
                 {8{group_toggle_enables[0]}}};
  assign sfr  = cmd_valid && (cmd.reg_sel == SEL_SFR);
  assign wr   = sfr && !cmd.rw && (cmd.addr == CMD_CTRL) && !pd_q;
  assign rd   = sfr && cmd.rw && (cmd.addr == CMD_CTRL);
  assign mon  = sfr && !cmd.rw && (cmd.addr == CMD_MON_SEL) && !pd_q;
  // Soft power-down tracking, writes are dropped meanwhile
  always_ff @(posedge clk) begin
    if (sys_rst || (sfr && !cmd.rw && cmd.addr == CMD_SOFT_PU)) begin
      pd_q <= 1'b0;
    end else if (sfr && !cmd.rw && cmd.addr == CMD_SOFT_PD) begin
      pd_q <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_wr;
    wr |=> ctrl == ($past(cmd.data) & CTRL_DEFINED);
  endproperty
  a_wr: assert property (p_wr) else $error("ctrl write");
  property p_rd;
    rd |=> rd_valid && (rd_data == $past(ctrl));
  endproperty
  a_rd: assert property (p_rd) else $error("ctrl read");
  property p_foreign;
    cmd_valid && (cmd.reg_sel != SEL_SFR) |=> $stable(ctrl) && !rd_valid;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign select");
  property p_tmap;
    channel_toggle_mode == tmap;
  endproperty
  a_tmap: assert property (p_tmap) else $error("toggle map");
  property p_mon;
    mon |=> monitor_channel == 6'($past(cmd.data) >> MON_ADDR_LSB);
  endproperty
  a_mon: assert property (p_mon) else $error("monitor address");
  property p_route;
    mon && monitor_enable_bit && (cmd.data[13:8] <= MON_LAST_ROUTED)
      |=> monitor_route_active && !monitor_output_hiz;
  endproperty
  a_route: assert property (p_route) else $error("monitor route");
  property p_last;
    last_channel_output_is_dac == !monitor_enable_bit;
  endproperty
  a_last: assert property (p_last) else $error("last channel");
  property p_srst;
    sfr && !cmd.rw && (cmd.addr == CMD_SOFT_RST) |=> ctrl == CTRL_DFLT && !monitor_route_active;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset");
  property p_therm;
    thermal_shutdown |-> !amps_powered;
  endproperty
  a_therm: assert property (p_therm) else $error("thermal");
endmodule : dcm_top_monitor

bind dcm_top dcm_top_monitor #(.REF_LEVEL_DEFAULT(REF_LEVEL_DEFAULT)) dcm_top_monitor_i (
  .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd), .rd_valid(rd_valid),
  .rd_data(rd_data), .powerdown_output_state(powerdown_output_state),
  .ref_level_select(ref_level_select), .amp_boost(amp_boost),
  .ref_source_internal(ref_source_internal), .monitor_enable_bit(monitor_enable_bit),
  .thermal_protect_enable(thermal_protect_enable), .group_toggle_enables(group_toggle_enables),
  .channel_toggle_mode(channel_toggle_mode), .amps_powered(amps_powered),
  .thermal_shutdown(thermal_shutdown), .monitor_channel(monitor_channel),
  .monitor_route_active(monitor_route_active), .monitor_output_hiz(monitor_output_hiz),
  .last_channel_output_is_dac(last_channel_output_is_dac));

// >>> testbench/dcm_host_model.sv
// Host model that issues command words to the control block
`timescale 1ns/1ps
module dcm_host_model
  import dcm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rd_valid,
  input  wire logic [DATA_W-1:0] rd_data,
  output logic                   cmd_valid,
  output dcm_cmd_s               cmd
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // One word per command at the falling edge; the idle word is scrambled
  task automatic send(input logic rw, input logic [1:0] sel, input logic [5:0] code,
                      input logic [DATA_W-1:0] data);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = {rw, sel, code, data};
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd = ~cmd;
  endtask : send
  // Control readback, waits a few cycles for the answer pulse
  task automatic read_ctrl(output logic [DATA_W-1:0] val);
    send(1'b1, SEL_SFR, CMD_CTRL, '0);
    for (int i = 0; i < 4 && rd_valid !== 1'b1; i++) begin
      @(negedge clk);
    end
    val = (rd_valid === 1'b1) ? rd_data : 'x;
  endtask : read_ctrl
endmodule : dcm_host_model

// >>> testbench/test_dcm_top.sv
// Self-checking bench of the control register and monitor select
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_dcm_top
  import dcm_pkg::*;
;
  logic              clk, sys_rst, over_temp_pin, load_dac_strobe_n, cmd_valid, rd_valid;
  dcm_cmd_s          cmd;
  logic [13:0]       rd_data;
  logic              pd_st, ref_lvl, boost, ref_int, mon_en, therm_en, amps, tsd;
  logic              mroute, mhiz, mundef, lastdac;
  logic [4:0]        tog;
  logic [NUM_CH-1:0] tmode, bsel;
  logic [5:0]        mch;
  logic [5:0]        mon_addr [4] = '{6'h00, 6'h26, 6'h27, 6'h3f};
  logic [3:0]        mon_exp  [4] = '{4'b1000, 4'b1000, 4'b0010, 4'b0100};
  int                miscompares = 0;
  int                samples_checked = 0;
  dcm_top #(.REF_LEVEL_DEFAULT(1'b1)) dcm_top_i (
    .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .over_temp_pin(over_temp_pin), .load_dac_strobe_n(load_dac_strobe_n),
    .rd_valid(rd_valid), .rd_data(rd_data), .powerdown_output_state(pd_st),
    .ref_level_select(ref_lvl), .amp_boost(boost), .ref_source_internal(ref_int),
    .monitor_enable_bit(mon_en), .thermal_protect_enable(therm_en),
    .group_toggle_enables(tog), .channel_toggle_mode(tmode), .channel_b_select(bsel),
    .amps_powered(amps), .thermal_shutdown(tsd), .monitor_channel(mch),
    .monitor_route_active(mroute), .monitor_output_hiz(mhiz), .monitor_undefined(mundef),
    .last_channel_output_is_dac(lastdac));
  dcm_host_model dcm_host_model_i (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data),
    .cmd_valid(cmd_valid), .cmd(cmd));
  // Clock of 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Command helpers, waits and the closing verdict
  task automatic sfr(input logic [5:0] code, input logic [13:0] d);
    dcm_host_model_i.send(1'b0, SEL_SFR, code, d);
  endtask : sfr
  task automatic rdchk(input logic [13:0] exp);
    logic [13:0] v;
    dcm_host_model_i.read_ctrl(v);
    `CHK(v, exp)
  endtask : rdchk
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic strobe;
    load_dac_strobe_n = 1'b0;
    idle(3);
    load_dac_strobe_n = 1'b1;
    idle(5);
  endtask : strobe
  task automatic tally_and_finish;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  // Watchdog against a hang
  initial begin
    #(40 * 3000);
    miscompares++;
    tally_and_finish();
  end
  // Main test sequence
  initial begin
    sys_rst = 1'b1;
    over_temp_pin = 1'b0;
    load_dac_strobe_n = 1'b1;
    idle(2);
    sys_rst = 1'b0;
    rdchk(14'h3000);
    `CHK({lastdac, amps, tsd}, 3'b110)
    sfr(CMD_CTRL, 14'h3fff);
    rdchk(14'h3f7c);
    sfr(CMD_CTRL, 14'h0000);
    `CHK({pd_st, ref_lvl, boost, ref_int, mon_en, therm_en}, 6'h00)
    for (int g = 0; g < NUM_GROUPS; g++) begin
      sfr(CMD_CTRL, 14'h0004 << g);
      `CHK(tmode, 40'hff << (8 * g))
    end
    dcm_host_model_i.send(1'b0, 2'h1, CMD_CTRL, 14'h3ffc);
    rdchk(14'h0040);
    strobe();
    `CHK(bsel, {8'hff, 32'h0})
    strobe();
    `CHK(bsel, 40'h0)
    sfr(CMD_MON_SEL, 14'h05ff);
    `CHK({mch, mroute, lastdac}, {6'h05, 2'b01})
    sfr(CMD_CTRL, 14'h0200);
    foreach (mon_addr[k]) begin
      sfr(CMD_MON_SEL, {mon_addr[k], 8'ha5});
      `CHK({mch, mroute, mhiz, mundef, lastdac}, {mon_addr[k], mon_exp[k]})
    end
    sfr(CMD_CTRL, 14'h0000);
    `CHK({mroute, lastdac}, 2'b01)
    over_temp_pin = 1'b1;
    idle(8);
    `CHK({tsd, amps}, 2'b01)
    sfr(CMD_CTRL, 14'h0100);
    idle(8);
    `CHK({tsd, amps}, 2'b10)
    sfr(CMD_SOFT_PU, 14'h0000);
    idle(3);
    `CHK({tsd, amps}, 2'b10)
    over_temp_pin = 1'b0;
    idle(4);
    sfr(CMD_SOFT_PU, 14'h0000);
    idle(3);
    `CHK({tsd, amps}, 2'b01)
    sfr(CMD_SOFT_PD, 14'h0000);
    idle(1);
    `CHK({tsd, amps}, 2'b00)
    sfr(CMD_CTRL, 14'h3e7c);
    rdchk(14'h0100);
    idle(1);
    `CHK(rd_valid, 1'b0)
    sfr(CMD_SOFT_PU, 14'h0000);
    idle(1);
    `CHK({tsd, amps}, 2'b01)
    sfr(CMD_CTRL, 14'h2e7c);
    sfr(CMD_SOFT_RST, 14'h0000);
    rdchk(14'h3000);
    tally_and_finish();
  end
endmodule : test_dcm_top
